// >>> hdl/ee_pkg.sv
// shared constants and carriers of the serial memory bus front end
package ee_pkg;
	localparam int WORD_ADDR_W = 16;
	localparam int PAGE_BITS = 7;
	localparam int DATA_W = 8;
	localparam logic [3:0] DEV_PREFIX = 4'ha;
	localparam logic [3:0] ACK_CNT = 4'h8;
	localparam logic [3:0] ACK_END_CNT = 4'h9;
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BUSY_CNT_W = 21;
	localparam int APB_AW = 12;
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam int CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h00000001;
	localparam int ST_STANDBY_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_SELECTED_BIT = 2;
	localparam int ST_WP_BIT = 3;
	localparam int ST_ADDR_LSB = 16;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEV = 3'h1,
		ST_ADDR_HI = 3'h2,
		ST_ADDR_LO = 3'h3,
		ST_WDATA = 3'h4,
		ST_RDATA = 3'h5,
		ST_IGNORE = 3'h6
	} bus_state_e;
endpackage

// >>> hdl/ee_mem.sv
// byte array with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module ee_mem #(
	parameter int AW = 16,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem_ff [0:(1<<AW)-1];
	logic [DW-1:0] rdata_ff;

	always_ff @(posedge clk) begin
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem_ff[raddr];
		end
	end

	assign rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> hdl/serial_eeprom_bus_front_end.sv
// two-wire serial slave front end of a byte-wide nonvolatile memory
// Behaviour
// (RULE1) sample on clock rise, shift out on fall
// (RULE2) data line only pulled low or released
// (RULE3) three select pins give distinct identity
// (RULE4) unconnected select pins read as low
// (RULE5) write protect high blocks all writes
// (RULE6) 512 pages of 128 bytes
// (RULE7) 16-bit word address after device word
// (RULE8) data changes only while clock low
// (RULE9) data falls, clock high: start
// (RULE10) data rises, clock high: stop, standby
// (RULE11) acknowledge low on ninth clock
// (RULE12) standby at power-up and after stop
// (RULE13) master recovers by clocking then start
// (RULE14) device word evaluated after each start
// (RULE15) top four bits match family prefix
// (RULE16) next three bits match select pins
// (RULE17) last bit one read, zero write
// (RULE18) acknowledge match, decline mismatch to standby
// (RULE19) busy write cycle withholds acknowledges
// (RULE20) page write advances low 7 bits
// (RULE21) after decline ignore until next start
// (RULE22) start mid-transfer restarts address reception
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_front_end #(
	parameter int WRITE_CYCLES = ee_pkg::WRITE_CYCLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] bus_select_pins,
	input wire logic wp_in,
	input wire ee_pkg::apb_req_s apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic standby
);
	import ee_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers and bus conditions
	// ------------------------------------------------------------
	logic [5:0] meta_ff;
	logic [5:0] sync_ff;
	logic scl_d_ff;
	logic sda_d_ff;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] sel_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 6'h03;
			sync_ff <= 6'h03;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			meta_ff <= {bus_select_pins, wp_in, sda_in, scl_in};
			sync_ff <= meta_ff;
			scl_d_ff <= sync_ff[0];
			sda_d_ff <= sync_ff[1];
		end
	end

	assign scl_s = sync_ff[0];
	assign sda_s = sync_ff[1];
	assign wp_s = sync_ff[2];
	// floating pins are pulled low outside, so they arrive as zero
	assign sel_s = sync_ff[5:3]; // (RULE4)
	assign scl_rise = scl_s & ~scl_d_ff; // (RULE1)
	assign scl_fall = ~scl_s & scl_d_ff; // (RULE1)
	assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s; // (RULE8) (RULE9)
	assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s; // (RULE8) (RULE10)

	// ------------------------------------------------------------
	// state, bit counter and shifters
	// ------------------------------------------------------------
	bus_state_e state_ff;
	logic [3:0] cnt_ff;
	logic [7:0] rx_ff;
	logic [7:0] tx_ff;
	logic nack_ff;
	logic busy_ff;
	logic wrote_ff;
	logic [BUSY_CNT_W-1:0] busy_cnt_ff;
	logic [WORD_ADDR_W-1:0] addr_ff;
	logic [31:0] ctrl_ff;
	logic sda_out_ff;
	logic sda_oe_ff;
	logic standby_ff;
	logic active;
	logic dev_match;
	logic to_read;
	logic mem_we;
	logic [DATA_W-1:0] mem_rd;

	assign active = (state_ff != ST_IDLE) && (state_ff != ST_IGNORE);
	assign dev_match = (rx_ff[7:4] == DEV_PREFIX) && (rx_ff[3:1] == sel_s) && !busy_ff; // (RULE3) (RULE15) (RULE16) (RULE19)
	assign to_read = ((state_ff == ST_DEV) && rx_ff[0]) || ((state_ff == ST_RDATA) && !nack_ff); // (RULE17)
	assign mem_we = active && scl_fall && (cnt_ff == ACK_CNT) && (state_ff == ST_WDATA) && !wp_s; // (RULE5)

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
		end else if (start_det) begin
			state_ff <= ctrl_ff[CTRL_EN_BIT] ? ST_DEV : ST_IDLE; // (RULE14) (RULE22)
			cnt_ff <= 4'h0;
		end else if (stop_det) begin
			state_ff <= ST_IDLE; // (RULE10)
			cnt_ff <= 4'h0;
		end else if (active) begin
			if (scl_rise && cnt_ff != ACK_END_CNT) begin
				cnt_ff <= cnt_ff + 4'h1;
			end else if (scl_fall && cnt_ff == ACK_CNT && state_ff == ST_DEV && !dev_match) begin
				state_ff <= ST_IGNORE; // (RULE18) (RULE21)
			end else if (scl_fall && cnt_ff == ACK_END_CNT) begin
				cnt_ff <= 4'h0;
				case (state_ff)
					ST_DEV: state_ff <= to_read ? ST_RDATA : ST_ADDR_HI; // (RULE17)
					ST_ADDR_HI: state_ff <= ST_ADDR_LO; // (RULE7)
					ST_ADDR_LO: state_ff <= ST_WDATA;
					ST_WDATA: state_ff <= ST_WDATA;
					ST_RDATA: state_ff <= to_read ? ST_RDATA : ST_IGNORE;
					default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// eight data bits shift in on rising clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ff <= 8'h00;
		end else if (active && scl_rise && cnt_ff < ACK_CNT) begin
			rx_ff <= {rx_ff[6:0], sda_s}; // (RULE1) (RULE11)
		end
	end

	// master acknowledge sampled on ninth rising clock of a read byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nack_ff <= 1'b0;
		end else if (start_det) begin
			nack_ff <= 1'b0;
		end else if (state_ff == ST_RDATA && scl_rise && cnt_ff == ACK_CNT) begin
			nack_ff <= sda_s;
		end
	end

	// ------------------------------------------------------------
	// data line drive: acknowledge and read data
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_ff <= 1'b0;
			tx_ff <= 8'h00;
		end else if (start_det || stop_det) begin
			sda_oe_ff <= 1'b0;
		end else if (!active) begin
			sda_oe_ff <= 1'b0; // (RULE21)
		end else if (scl_fall) begin
			if (cnt_ff == ACK_CNT) begin
				sda_oe_ff <= (state_ff != ST_RDATA) && (state_ff != ST_DEV || dev_match); // (RULE11) (RULE18)
			end else if (cnt_ff == ACK_END_CNT) begin
				tx_ff <= mem_rd;
				sda_oe_ff <= to_read && !mem_rd[7]; // (RULE1)
			end else if (state_ff == ST_RDATA) begin
				tx_ff <= {tx_ff[6:0], 1'b0};
				sda_oe_ff <= !tx_ff[6]; // (RULE1) (RULE8)
			end
		end
	end

	// output level is always low; only the enable moves
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out_ff <= 1'b0;
		end else begin
			sda_out_ff <= 1'b0; // (RULE2)
		end
	end

	// ------------------------------------------------------------
	// word address counter
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= '0;
		end else if (active && scl_fall && cnt_ff == ACK_CNT && state_ff == ST_ADDR_HI) begin
			addr_ff[15:8] <= rx_ff; // (RULE7)
		end else if (active && scl_fall && cnt_ff == ACK_CNT && state_ff == ST_ADDR_LO) begin
			addr_ff[7:0] <= rx_ff; // (RULE7)
		end else if (active && scl_fall && cnt_ff == ACK_CNT && state_ff == ST_WDATA) begin
			addr_ff[PAGE_BITS-1:0] <= addr_ff[PAGE_BITS-1:0] + 7'h01; // (RULE6) (RULE20)
		end else if (state_ff == ST_RDATA && scl_rise && cnt_ff == ACK_CNT) begin
			addr_ff <= addr_ff + 16'h0001;
		end
	end

	ee_mem #(
		.AW(WORD_ADDR_W),
		.DW(DATA_W)
	) u_mem (
		.clk(clk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr(addr_ff),
		.wdata(rx_ff),
		.raddr(addr_ff),
		.rdata(mem_rd)
	);

	// ------------------------------------------------------------
	// internal write cycle and standby
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrote_ff <= 1'b0;
		end else if (start_det || stop_det) begin
			wrote_ff <= 1'b0;
		end else if (mem_we) begin
			wrote_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			busy_cnt_ff <= '0;
		end else if (stop_det && wrote_ff) begin
			busy_ff <= 1'b1; // (RULE19)
			busy_cnt_ff <= BUSY_CNT_W'(WRITE_CYCLES - 1);
		end else if (busy_ff) begin
			if (busy_cnt_ff == '0) begin
				busy_ff <= 1'b0;
			end else begin
				busy_cnt_ff <= busy_cnt_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			standby_ff <= 1'b1; // (RULE12)
		end else begin
			standby_ff <= !active && !busy_ff; // (RULE12) (RULE18)
		end
	end

	// ------------------------------------------------------------
	// register slave
	// ------------------------------------------------------------
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic apb_hit;

	assign apb_hit = (apb_req.paddr == CTRL_OFS) || (apb_req.paddr == STATUS_OFS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= apb_req.psel && apb_req.penable && !pready_ff;
			pslverr_ff <= apb_req.psel && apb_req.penable && !pready_ff && !apb_hit;
			prdata_ff <= 32'h00000000;
			if (apb_req.psel && apb_req.penable && !pready_ff && !apb_req.pwrite) begin
				if (apb_req.paddr == CTRL_OFS) begin
					prdata_ff <= {31'h00000000, ctrl_ff[CTRL_EN_BIT]};
				end else if (apb_req.paddr == STATUS_OFS) begin
					prdata_ff[ST_STANDBY_BIT] <= standby_ff;
					prdata_ff[ST_BUSY_BIT] <= busy_ff;
					prdata_ff[ST_SELECTED_BIT] <= active && state_ff != ST_DEV;
					prdata_ff[ST_WP_BIT] <= wp_s;
					prdata_ff[ST_ADDR_LSB +: WORD_ADDR_W] <= addr_ff;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RST;
		end else if (apb_req.psel && apb_req.penable && pready_ff && apb_req.pwrite
			&& apb_req.paddr == CTRL_OFS) begin
			ctrl_ff <= {31'h00000000, apb_req.pwdata[CTRL_EN_BIT]};
		end
	end

	assign sda_out = sda_out_ff;
	assign sda_oe = sda_oe_ff;
	assign standby = standby_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata = prdata_ff;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_low_only;
		@(posedge clk) disable iff (!rst_n) $rose(sda_oe_ff) |-> !sda_out_ff;
	endproperty
	a_low_only: assert property (p_low_only) else $error("data line driven high"); // (RULE2)

	property p_change_low;
		@(posedge clk) disable iff (!rst_n)
			$changed(sda_oe_ff) |-> !$past(scl_s) || $past(start_det || stop_det);
	endproperty
	a_change_low: assert property (p_change_low) else $error("drive changed, clock high"); // (RULE8)

	property p_start_restart;
		@(posedge clk) disable iff (!rst_n)
			start_det && ctrl_ff[CTRL_EN_BIT] |=> state_ff == ST_DEV && cnt_ff == 4'h0 && !sda_oe_ff;
	endproperty
	a_start_restart: assert property (p_start_restart) else $error("start did not restart"); // (RULE22)

	property p_stop_idle;
		@(posedge clk) disable iff (!rst_n) stop_det |=> state_ff == ST_IDLE ##1 standby_ff == !$past(busy_ff);
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not reach standby"); // (RULE10)

	property p_dev_ack;
		@(posedge clk) disable iff (!rst_n)
			active && scl_fall && cnt_ff == ACK_CNT && state_ff == ST_DEV |=> sda_oe_ff == $past(dev_match);
	endproperty
	a_dev_ack: assert property (p_dev_ack) else $error("device word answer wrong"); // (RULE11)

	property p_mismatch;
		@(posedge clk) disable iff (!rst_n)
			active && scl_fall && cnt_ff == ACK_CNT && state_ff == ST_DEV
			&& rx_ff[7:4] != DEV_PREFIX && !start_det && !stop_det |=> state_ff == ST_IGNORE;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("foreign word not declined"); // (RULE18)

	property p_busy_quiet;
		@(posedge clk) disable iff (!rst_n) busy_ff && state_ff == ST_DEV |=> !$rose(sda_oe_ff);
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("acknowledge while busy"); // (RULE19)

	property p_wp_block;
		@(posedge clk) disable iff (!rst_n) mem_we |-> !wp_s && !busy_ff;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("write while protected"); // (RULE5)

	property p_page_wrap;
		@(posedge clk) disable iff (!rst_n)
			mem_we |=> addr_ff == {$past(addr_ff[15:7]), 7'($past(addr_ff[6:0]) + 7'h01)};
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page address advance wrong"); // (RULE20)

	property p_ignore_hold;
		@(posedge clk) disable iff (!rst_n) state_ff == ST_IGNORE && !start_det |=> !sda_oe_ff;
	endproperty
	a_ignore_hold: assert property (p_ignore_hold) else $error("drive after decline"); // (RULE21)
endmodule
`default_nettype wire

// >>> hdl/serial_eeprom_bus_front_end_unused.sv
// holds no logic of its own

// >>> verif/ee_master.sv
// bus master model that drives the two-wire link
`timescale 1ns/1ps
`default_nettype none
module ee_master (
	input wire logic clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_o
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	task automatic wq(input int n);
		repeat (n) @(posedge clk);
	endtask
	// data moves while the clock is low, read back mid-high
	task automatic bit_x(input logic b, output logic r);
		wq(5);
		sda_o <= b;
		wq(15);
		scl <= 1'b1;
		wq(10);
		r = sda_w;
		wq(10);
		scl <= 1'b0;
	endtask
	task automatic start;
		wq(5);
		sda_o <= 1'b1;
		wq(15);
		scl <= 1'b1;
		wq(10);
		sda_o <= 1'b0;
		wq(10);
		scl <= 1'b0;
	endtask
	// clock stays high afterwards: idle bus
	task automatic stop;
		wq(5);
		sda_o <= 1'b0;
		wq(15);
		scl <= 1'b1;
		wq(10);
		sda_o <= 1'b1;
		wq(20);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
		output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], r);
			rx[i] = r;
		end
		bit_x(mack, ak);
	endtask
	// clock up to nine times; start in the first high phase that reads free
	task automatic recover;
		for (int i = 0; i < 9; i++) begin
			wq(5);
			sda_o <= 1'b1;
			wq(15);
			scl <= 1'b1;
			wq(10);
			if (sda_w === 1'b1) break;
			wq(10);
			scl <= 1'b0;
		end
		sda_o <= 1'b0;
		wq(10);
		scl <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verif/serial_eeprom_bus_front_end_tb.sv
// self-checking bench of the serial memory bus front end
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_front_end_tb;
	import ee_pkg::*;
	// long enough that a poll's device word lands inside the write cycle
	localparam int WC = 800;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] sel = 3'h0;
	logic wp = 1'b0;
	apb_req_s apb_req = '0;
	logic [31:0] prdata, r32;
	logic pready, pslverr, standby, sda_out, sda_oe, scl, sda_o, sda_w, ak, e1;
	logic [15:0] a;
	logic [7:0] d, rx;
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 32'h19b4a030;
	always #2 clk = ~clk;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_o;
	serial_eeprom_bus_front_end #(.WRITE_CYCLES(WC)) dut (.clk(clk), .rst_n(rst_n), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .bus_select_pins(sel), .wp_in(wp),
		.apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby));
	ee_master m (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_o(sda_o));
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
		output logic [31:0] rdv, output logic er);
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: wd};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) begin
			$display("Error at %0t: no ready got %h expected %h", $time, pready, 1'b1);
			error_cnt++;
			tally_and_finish();
		end
		rdv = prdata;
		er = pslverr;
		apb_req <= '0;
	endtask
	function automatic logic [7:0] devw(input logic [3:0] p, input logic [2:0] s, input logic rw);
		return {p, s, rw};
	endfunction
	task automatic hdr(input logic [15:0] ad);
		m.start();
		m.xfer(devw(DEV_PREFIX, sel, 1'b0), 1'b1, rx, ak);
		chk(ak, 1'b0);
		m.xfer(ad[15:8], 1'b1, rx, ak);
		chk(ak, 1'b0);
		m.xfer(ad[7:0], 1'b1, rx, ak);
		chk(ak, 1'b0);
	endtask
	task automatic wr_b(input logic [15:0] ad, input logic [7:0] dv, input int n);
		hdr(ad);
		for (int i = 0; i < n; i++) begin
			m.xfer(dv + 8'(i), 1'b1, rx, ak);
			chk(ak, 1'b0);
		end
		m.stop();
		repeat (10) @(posedge clk);
		chk(standby, wp);
		repeat (WC + 30) @(posedge clk);
		chk(standby, 1'b1);
	endtask
	task automatic rd_b(input logic [15:0] ad, input logic [7:0] e);
		hdr(ad);
		m.start();
		m.xfer(devw(DEV_PREFIX, sel, 1'b1), 1'b1, rx, ak);
		chk(ak, 1'b0);
		m.xfer(8'hff, 1'b1, rx, ak);
		chk(rx, e);
		m.stop();
		repeat (8) @(posedge clk);
		chk(standby, 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(standby, 1'b1);
		chk(sda_oe, 1'b0);
		apb(1'b0, CTRL_OFS, 32'h0, r32, e1);
		chk(r32, CTRL_RST);
		apb(1'b0, 12'h008, 32'h0, r32, e1);
		chk(e1, 1'b1);
		$display("test reset done");
		for (int s = 0; s < 8; s++) begin
			sel <= 3'(s);
			a = 16'($random(seed));
			d = 8'($random(seed));
			wr_b(a, d, 1);
			rd_b(a, d);
		end
		$display("test select done");
		m.start();
		m.xfer(devw(DEV_PREFIX, ~sel, 1'b0), 1'b1, rx, ak);
		chk(ak, 1'b1);
		m.xfer(devw(DEV_PREFIX, sel, 1'b0), 1'b1, rx, ak);
		chk(ak, 1'b1);
		chk(standby, 1'b1);
		m.start();
		m.xfer(devw(4'h5, sel, 1'b0), 1'b1, rx, ak);
		chk(ak, 1'b1);
		m.stop();
		$display("test decline done");
		a = {a[15:7], 7'h7f};
		wr_b(a, d, 2);
		rd_b({a[15:7], 7'h00}, d + 8'h01);
		wp <= 1'b1;
		wr_b(a, ~d, 1);
		wp <= 1'b0;
		rd_b(a, d);
		$display("test page and protect done");
		hdr(a);
		m.xfer(~d, 1'b1, rx, ak);
		m.stop();
		m.start();
		m.xfer(devw(DEV_PREFIX, sel, 1'b1), 1'b1, rx, ak);
		chk(ak, 1'b1);
		m.stop();
		repeat (WC + 40) @(posedge clk);
		rd_b(a, ~d);
		$display("test busy done");
		// current address on the page start, whose byte is known
		hdr({a[15:7], 7'h00});
		m.start();
		for (int i = 0; i < 4; i++) m.bit_x(1'b1, ak);
		m.start();
		m.xfer(devw(DEV_PREFIX, sel, 1'b1), 1'b1, rx, ak);
		chk(ak, 1'b0);
		for (int i = 0; i < 3; i++) m.bit_x(1'b1, ak);
		m.recover();
		m.xfer(devw(DEV_PREFIX, sel, 1'b0), 1'b1, rx, ak);
		chk(ak, 1'b0);
		m.stop();
		apb(1'b1, CTRL_OFS, 32'h0, r32, e1);
		m.start();
		m.xfer(devw(DEV_PREFIX, sel, 1'b0), 1'b1, rx, ak);
		chk(ak, 1'b1);
		m.stop();
		apb(1'b1, CTRL_OFS, CTRL_RST, r32, e1);
		apb(1'b0, STATUS_OFS, 32'h0, r32, e1);
		chk(r32[ST_STANDBY_BIT], 1'b1);
		$display("test recovery done");
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
